// [optical_sensor_config_regs.sv]
// Purpose: I2C target register bank for light and proximity setup
// Assumes: scl_i and sda_i synchronous to clk_i, far faster than the bus
// Notes: Open-drain pins are driven low only while the matching _oe_o is high
//
// Function
// (RL1) Bit 0 of light2 control selects continuous
// (RL2) Oversample codes 0..4 map to 32..512
// (RL3) Rate codes 0..7 map to 1..128 periods
// (RL4) Gain codes 1..6 decode 1X to 32X
// (RL5) Front-end offset is 25 bits, resets zero
// (RL6) LED pulse width is 2us plus N us
// (RL7) Multi-sample codes pick 1 to 256 samples
// (RL8) Threshold flag needs 1/2/4/8 consecutive hits
// (RL9) Idle code 0 none, else tick table
// (RL10) Lock bit 6 selects pulse or level interrupt
// (RL11) Writing lock bit 5 clears interrupt and flags
// (RL12) Interrupt pulse width counts 625 ns units
// (RL13) LED current field counts 1 mA steps
// (RL14) Answer only target address 0x2B
// (RL15) Register index advances after each byte
// (RL16) Standard writes and repeated-start reads supported
// (RL17) Read-clear enable clears flags on read
// (RL18) Four proximity threshold flags in status
// (RL19) In level mode, interrupt pin low while enabled flag pending
// (RL20) Timeout flag sets at count, sticks
module optical_sensor_config_regs (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic prox_sample_i,
  input wire logic [3:0] prox_cond_i,
  output logic interrupt_out_n_o,
  output logic interrupt_out_n_oe_o,
  output logic light2_continuous_o,
  output logic light2_enable_o,
  output logic [6:0] averaging_count_o,
  output logic [9:0] oversample_ratio_o,
  output logic [7:0] rate_interval_count_o,
  output logic [5:0] light2_gain_o,
  output logic [5:0] light3_gain_o,
  output logic [5:0] light4_gain_o,
  output logic [24:0] analog_front_end_offset_o,
  output logic [6:0] led_pulse_us_o,
  output logic [3:0] led_current_ma_o,
  output logic [8:0] analog_samples_o,
  output logic [8:0] digital_samples_o,
  output logic [22:0] idle_ticks_o,
  output logic [15:0] prox_high1_o,
  output logic [15:0] prox_low1_o,
  output logic [7:0] baseline_rise_limit_o,
  output logic [7:0] proximity_baseline_low_o
);
  // ==========================================================================
  // Decode helpers
  function automatic logic [5:0] gain_mult(input logic [3:0] code);
    gain_mult = 6'h00;
    if (code != 4'h0 && code <= sensor_cfg_pkg::GAIN_MAX_CODE) begin
      gain_mult = 6'(6'h01 << (code - 4'h1));
    end
  endfunction : gain_mult

  function automatic logic [8:0] samples(input logic [3:0] code);
    samples = 9'h100;
    if (code <= sensor_cfg_pkg::MS_MAX_CODE) begin
      samples = 9'(9'h001 << code);
    end
  endfunction : samples

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_INDEX, ST_WRITE, ST_READ} i2c_state_t;

  logic [7:0] rf_q [sensor_cfg_pkg::NUM_REGS];
  i2c_state_t state_q;
  logic scl_q, sda_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_q, tx_q, index_q;
  logic ack_q, sda_oe_q;
  logic [3:0] prox_flags_q;
  logic tmo_flag_q;
  logic [12:0] acc_q;
  logic tick;
  logic [7:0] tmo_cnt_q;
  logic [15:0] pulse_cnt_q;
  logic pending_q, int_act_q;
  logic [3:0] prox_set;
  logic [3:0] persist_need;

  // ==========================================================================
  // Bus condition detection
  logic scl_rise, scl_fall, start_cond, stop_cond, byte_done, wr_stb, rd_load;
  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign start_cond = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_cond = scl_i & scl_q & ~sda_q & sda_i;
  assign byte_done = scl_fall & (bit_cnt_q == sensor_cfg_pkg::BITS_PER_BYTE) & ~ack_q;
  assign wr_stb = byte_done & (state_q == ST_WRITE);
  // The next read byte is fetched as each acknowledge slot ends, except after a host NACK
  assign rd_load = scl_fall & ack_q & (state_q == ST_READ);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (en_i) begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // ==========================================================================
  // Read data
  logic [7:0] rd_data;
  always_comb begin
    rd_data = 8'h00;
    for (int i = 0; i < sensor_cfg_pkg::NUM_REGS; i++) begin
      if (index_q == sensor_cfg_pkg::REG_OFFS[i]) begin
        rd_data = rf_q[i];
      end
    end
    if (index_q == sensor_cfg_pkg::OFF_PROX_FLAGS) begin
      rd_data = {4'h0, prox_flags_q}; // see (RL18)
    end
    if (index_q == sensor_cfg_pkg::OFF_TMO_FLAG) begin
      rd_data[sensor_cfg_pkg::TMO_FLAG_BIT] = tmo_flag_q;
    end
  end

  // ==========================================================================
  // I2C target engine
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (en_i) begin
      if (start_cond) begin
        // Repeated start lands here too, keeping the index for the read
        state_q <= ST_ADDR; // see (RL16)
        bit_cnt_q <= 4'h0;
        ack_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (stop_cond) begin
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end else if (scl_rise && state_q != ST_IDLE) begin
        if (bit_cnt_q < sensor_cfg_pkg::BITS_PER_BYTE) begin
          rx_q <= {rx_q[6:0], sda_i};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end else if (ack_q && state_q == ST_READ && sda_i) begin
          state_q <= ST_IDLE;
        end
      end else if (scl_fall && state_q != ST_IDLE) begin
        if (byte_done) begin
          ack_q <= 1'b1;
          case (state_q)
            ST_ADDR: begin
              if (rx_q[7:1] == sensor_cfg_pkg::TARGET_ADDR) begin // see (RL14)
                sda_oe_q <= 1'b1;
                state_q <= rx_q[0] ? ST_READ : ST_INDEX;
              end else begin
                state_q <= ST_IDLE;
              end
            end
            ST_INDEX: begin
              sda_oe_q <= 1'b1;
              state_q <= ST_WRITE;
            end
            ST_WRITE: begin
              sda_oe_q <= 1'b1;
            end
            default: begin
              sda_oe_q <= 1'b0;
            end
          endcase
        end else if (ack_q) begin
          ack_q <= 1'b0;
          bit_cnt_q <= 4'h0;
          if (state_q == ST_READ) begin
            tx_q <= rd_data;
            sda_oe_q <= ~rd_data[7];
          end else begin
            sda_oe_q <= 1'b0;
          end
        end else if (state_q == ST_READ) begin
          tx_q <= {tx_q[6:0], 1'b0};
          sda_oe_q <= ~tx_q[6];
        end
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      index_q <= 8'h00;
    end else if (en_i) begin
      if (byte_done && state_q == ST_INDEX) begin
        index_q <= rx_q;
      end else if (wr_stb || rd_load) begin
        index_q <= index_q + 8'h01; // see (RL15)
      end
    end
  end

  // ==========================================================================
  // Register storage
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < sensor_cfg_pkg::NUM_REGS; i++) begin
        rf_q[i] <= sensor_cfg_pkg::REG_RST[i];
      end
    end else if (en_i && wr_stb) begin
      for (int i = 0; i < sensor_cfg_pkg::NUM_REGS; i++) begin
        if (index_q == sensor_cfg_pkg::REG_OFFS[i]) begin
          rf_q[i] <= rx_q & sensor_cfg_pkg::REG_MASK[i];
        end
      end
    end
  end

  // ==========================================================================
  // Flags and persistence
  logic manual_clr, read_clr, tmo_wclr, tmo_en;
  // Manual clear bit is a command and is never stored
  assign manual_clr = wr_stb & (index_q == sensor_cfg_pkg::OFF_LOCK)
                      & rx_q[sensor_cfg_pkg::LOCK_MANCLR_BIT]; // see (RL11)
  assign read_clr = rd_load & (index_q == sensor_cfg_pkg::OFF_PROX_FLAGS)
                    & rf_q[sensor_cfg_pkg::S_IRQ_EN][sensor_cfg_pkg::IRQ_RDCLR_BIT]; // see (RL17)
  assign tmo_wclr = wr_stb & (index_q == sensor_cfg_pkg::OFF_TMO_FLAG)
                    & rx_q[sensor_cfg_pkg::TMO_FLAG_BIT];
  assign tmo_en = rf_q[sensor_cfg_pkg::S_LOCK][sensor_cfg_pkg::LOCK_TMO_EN_BIT];
  assign persist_need = 4'(4'h1 << rf_q[sensor_cfg_pkg::S_PERSIST][1:0]);

  for (genvar g = 0; g < sensor_cfg_pkg::NUM_PROX_FLAGS; g++) begin : g_persist
    logic [3:0] hits_q;
    // A run that already fired saturates, so one crossing raises the flag once
    assign prox_set[g] = prox_sample_i & prox_cond_i[g]
                         & (hits_q + 4'h1 == persist_need); // see (RL8)
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        hits_q <= 4'h0;
      end else if (en_i && prox_sample_i) begin
        if (!prox_cond_i[g]) begin
          hits_q <= 4'h0;
        end else if (hits_q < persist_need) begin
          hits_q <= hits_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prox_flags_q <= 4'h0;
    end else if (en_i) begin
      // Set wins over a clear in the same cycle
      prox_flags_q <= (prox_flags_q & ~{4{manual_clr | read_clr}}) | prox_set; // see (RL18)
    end
  end

  // ==========================================================================
  // Timing tick and timeout
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_q <= 13'h0000;
    end else if (en_i) begin
      if (acc_q + sensor_cfg_pkg::ACC_STEP >= sensor_cfg_pkg::ACC_MOD) begin
        acc_q <= acc_q + sensor_cfg_pkg::ACC_STEP - sensor_cfg_pkg::ACC_MOD;
      end else begin
        acc_q <= acc_q + sensor_cfg_pkg::ACC_STEP;
      end
    end
  end
  assign tick = acc_q + sensor_cfg_pkg::ACC_STEP >= sensor_cfg_pkg::ACC_MOD;

  logic tmo_hit;
  assign tmo_hit = tmo_en & ~tmo_flag_q & tick & (tmo_cnt_q == rf_q[sensor_cfg_pkg::S_TMO]);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tmo_cnt_q <= 8'h00;
    end else if (en_i) begin
      if (!tmo_en || tmo_flag_q || tmo_hit) begin
        tmo_cnt_q <= 8'h00;
      end else if (tick) begin
        tmo_cnt_q <= tmo_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tmo_flag_q <= 1'b0;
    end else if (en_i) begin
      if (tmo_hit) begin
        tmo_flag_q <= 1'b1; // see (RL20)
      end else if (manual_clr || tmo_wclr) begin
        tmo_flag_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Interrupt pin
  logic pending, level_mode;
  logic [15:0] pulse_len;
  assign pending = (|prox_flags_q & rf_q[sensor_cfg_pkg::S_IRQ_EN][sensor_cfg_pkg::IRQ_PROX_EN_BIT])
                   | (tmo_flag_q & tmo_en);
  assign level_mode = rf_q[sensor_cfg_pkg::S_LOCK][sensor_cfg_pkg::LOCK_LEVEL_BIT];
  assign pulse_len = 16'({rf_q[sensor_cfg_pkg::S_IW_HI][6:0], rf_q[sensor_cfg_pkg::S_IW_LO]}
                         * sensor_cfg_pkg::INT_UNIT_TICKS); // see (RL12)

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pending_q <= 1'b0;
      pulse_cnt_q <= 16'h0000;
    end else if (en_i) begin
      pending_q <= pending;
      if (manual_clr) begin
        pulse_cnt_q <= 16'h0000;
      end else if (pending && !pending_q) begin
        pulse_cnt_q <= pulse_len;
      end else if (tick && pulse_cnt_q != 16'h0000) begin
        pulse_cnt_q <= pulse_cnt_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_act_q <= 1'b0;
    end else if (en_i) begin
      if (level_mode) begin
        int_act_q <= pending; // see (RL10) (RL19)
      end else begin
        int_act_q <= (pulse_cnt_q != 16'h0000) & ~manual_clr; // see (RL10)
      end
    end
  end

  assign interrupt_out_n_o = ~int_act_q;
  assign interrupt_out_n_oe_o = int_act_q;

  // ==========================================================================
  // Decoded configuration outputs
  logic [2:0] osr_code, avg_code;
  assign osr_code = rf_q[sensor_cfg_pkg::S_L2_OSR][sensor_cfg_pkg::OSR_LSB +: 3];
  assign avg_code = rf_q[sensor_cfg_pkg::S_L2_AVG][sensor_cfg_pkg::AVG_LSB +: 3];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      light2_continuous_o <= 1'b0;
      light2_enable_o <= 1'b0;
      averaging_count_o <= 7'h00;
      oversample_ratio_o <= 10'h000;
      rate_interval_count_o <= 8'h00;
      light2_gain_o <= 6'h00;
      light3_gain_o <= 6'h00;
      light4_gain_o <= 6'h00;
      analog_front_end_offset_o <= 25'h0000000;
      led_pulse_us_o <= 7'h00;
      led_current_ma_o <= 4'h0;
      analog_samples_o <= 9'h000;
      digital_samples_o <= 9'h000;
      idle_ticks_o <= 23'h000000;
      prox_high1_o <= 16'h0000;
      prox_low1_o <= 16'h0000;
      baseline_rise_limit_o <= 8'h00;
      proximity_baseline_low_o <= 8'h00;
    end else if (en_i) begin
      light2_continuous_o <= rf_q[sensor_cfg_pkg::S_L2_AVG][sensor_cfg_pkg::CONT_BIT]; // see (RL1)
      light2_enable_o <= rf_q[sensor_cfg_pkg::S_L2_EN][sensor_cfg_pkg::EN_BIT];
      averaging_count_o <= (avg_code <= sensor_cfg_pkg::AVG_MAX_CODE)
                           ? 7'(7'h01 << avg_code) : 7'h40;
      oversample_ratio_o <= (osr_code <= sensor_cfg_pkg::OSR_MAX_CODE)
                            ? 10'(sensor_cfg_pkg::OSR_BASE << osr_code) : 10'h200; // see (RL2)
      rate_interval_count_o <= 8'(8'h01 << rf_q[sensor_cfg_pkg::S_L2_RATE][2:0]); // see (RL3)
      light2_gain_o <= gain_mult(rf_q[sensor_cfg_pkg::S_L2_GAIN][3:0]); // see (RL4)
      light3_gain_o <= gain_mult(rf_q[sensor_cfg_pkg::S_L3_GAIN][3:0]); // see (RL4)
      light4_gain_o <= gain_mult(rf_q[sensor_cfg_pkg::S_L4_GAIN][3:0]); // see (RL4)
      analog_front_end_offset_o <= {rf_q[sensor_cfg_pkg::S_AFE3][0], rf_q[sensor_cfg_pkg::S_AFE2],
                                    rf_q[sensor_cfg_pkg::S_AFE1],
                                    rf_q[sensor_cfg_pkg::S_AFE0]}; // see (RL5)
      led_pulse_us_o <= 7'(sensor_cfg_pkg::LED_BASE_US + sensor_cfg_pkg::LED_STEP_US
                        * int'(rf_q[sensor_cfg_pkg::S_LED_PULSE][7:sensor_cfg_pkg::LED_PW_LSB]));
      // see (RL6)
      led_current_ma_o <= 4'(sensor_cfg_pkg::LED_STEP_MA
                          * int'(rf_q[sensor_cfg_pkg::S_LED_CUR][6:sensor_cfg_pkg::LED_CUR_LSB]));
      // see (RL13)
      analog_samples_o <= samples(rf_q[sensor_cfg_pkg::S_MS_ANA][3:0]); // see (RL7)
      digital_samples_o <= samples(rf_q[sensor_cfg_pkg::S_MS_DIG][3:0]); // see (RL7)
      idle_ticks_o <= sensor_cfg_pkg::IDLE_TICKS[rf_q[sensor_cfg_pkg::S_IDLE][4:0]]; // see (RL9)
      prox_high1_o <= {rf_q[sensor_cfg_pkg::S_HI1_HI], rf_q[sensor_cfg_pkg::S_HI1_LO]};
      prox_low1_o <= {rf_q[sensor_cfg_pkg::S_LO1_HI], rf_q[sensor_cfg_pkg::S_LO1_LO]};
      baseline_rise_limit_o <= rf_q[sensor_cfg_pkg::S_BL_UP];
      proximity_baseline_low_o <= rf_q[sensor_cfg_pkg::S_BL_LOW];
    end
  end
endmodule : optical_sensor_config_regs

// [sensor_cfg_pkg.sv]
// Purpose: Shared constants for the sensor register bank
// Assumes: 50 MHz system clock, 1.6 MHz internal timing tick
// Notes: Slots index the storage array
package sensor_cfg_pkg;
  // ==========================================================================
  // Bus and timing
  localparam logic [6:0] TARGET_ADDR = 7'h2B;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_HZ = 1_600_000;
  localparam int ACC_GCD = 10_000;
  localparam logic [12:0] ACC_STEP = 13'(TICK_HZ / ACC_GCD);
  localparam logic [12:0] ACC_MOD = 13'(CLK_HZ / ACC_GCD);
  localparam int INT_UNIT_NS = 625;
  localparam int INT_UNIT_TICKS = INT_UNIT_NS * (TICK_HZ / 1000) / 1_000_000;
  localparam int LED_BASE_US = 2;
  localparam int LED_STEP_US = 1;
  localparam int LED_STEP_MA = 1;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFF_IRQ_EN = 8'h14;
  localparam logic [7:0] OFF_PROX_FLAGS = 8'h18;
  localparam logic [7:0] OFF_LOCK = 8'h83;
  localparam logic [7:0] OFF_TMO_FLAG = 8'h86;
  // ==========================================================================
  // Storage slots
  localparam int NUM_REGS = 33;
  localparam int S_L2_AVG = 0, S_L2_OSR = 1, S_L2_RATE = 2, S_L2_EN = 3, S_L2_GAIN = 4;
  localparam int S_AFE0 = 5, S_AFE1 = 6, S_AFE2 = 7, S_AFE3 = 8, S_L3_GAIN = 9;
  localparam int S_L4_GAIN = 10, S_LED_PULSE = 11, S_MS_ANA = 12, S_MS_DIG = 13;
  localparam int S_PERSIST = 16, S_HI1_LO = 17, S_HI1_HI = 18, S_LO1_LO = 19;
  localparam int S_LO1_HI = 20, S_BL_UP = 24, S_BL_LOW = 25, S_IDLE = 26, S_LOCK = 27;
  localparam int S_TMO = 28, S_IW_LO = 29, S_IW_HI = 30, S_LED_CUR = 31, S_IRQ_EN = 32;
  localparam logic [7:0] REG_OFFS [NUM_REGS] = '{
    8'h30, 8'h31, 8'h33, 8'h34, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h4A, 8'h4B,
    8'h53, 8'h5A, 8'h5B, 8'h60, 8'h61, 8'h62, 8'h64, 8'h65, 8'h66, 8'h67, 8'h6C,
    8'h6D, 8'h6E, 8'h6F, 8'h70, 8'h80, OFF_LOCK, 8'h84, 8'h87, 8'h88, 8'hE3, OFF_IRQ_EN};
  localparam logic [7:0] REG_RST [NUM_REGS] = '{
    8'h30, 8'h45, 8'h00, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h06, 8'h06,
    8'hF4, 8'h02, 8'h01, 8'h00, 8'h10, 8'h00, 8'hE8, 8'h03, 8'h68, 8'h01, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h80, 8'h16, 8'h01, 8'h00, 8'h40, 8'h06, 8'h7F, 8'h02};
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{
    8'h71, 8'hFF, 8'h07, 8'h01, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h0F, 8'h0F,
    8'hFF, 8'h0F, 8'h0F, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'h01, 8'hFF, 8'hFF, 8'h1F, 8'h5F, 8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'h13};
  // ==========================================================================
  // Field positions
  localparam int CONT_BIT = 0, EN_BIT = 0, AVG_LSB = 4, OSR_LSB = 4;
  localparam int LED_PW_LSB = 2, LED_CUR_LSB = 3;
  localparam int IRQ_PROX_EN_BIT = 1, IRQ_RDCLR_BIT = 4;
  localparam int LOCK_LEVEL_BIT = 6, LOCK_MANCLR_BIT = 5, LOCK_TMO_EN_BIT = 2;
  localparam int TMO_FLAG_BIT = 1;
  localparam int NUM_PROX_FLAGS = 4;
  localparam logic [9:0] OSR_BASE = 10'h020;
  localparam logic [2:0] OSR_MAX_CODE = 3'h4;
  localparam logic [2:0] AVG_MAX_CODE = 3'h6;
  localparam logic [3:0] GAIN_MAX_CODE = 4'h6;
  localparam logic [3:0] MS_MAX_CODE = 4'h8;
  // Idle time per code, in 1.6 MHz ticks
  localparam logic [22:0] IDLE_TICKS [32] = '{
    23'h0, 23'h280, 23'h3C0, 23'h500, 23'h640, 23'hC80, 23'h1900, 23'h2580,
    23'h3200, 23'h3E80, 23'h4B00, 23'h5780, 23'h6400, 23'h7D00, 23'h9C40, 23'hBB80,
    23'hFA00, 23'h13880, 23'h17700, 23'h1D4C0, 23'h1F400, 23'h23280, 23'h27100,
    23'h4E200, 23'h75300, 23'h9C400, 23'h138800, 23'h186A00, 23'h271000,
    23'h30D400, 23'h493E00, 23'h61A800};
endpackage : sensor_cfg_pkg

// [osc_cfg_chk.sv]
// Purpose: Port assertions for the sensor bank
// Assumes: One clock, async active-low reset
// Notes: Decoded outputs checked for legal codes
module osc_cfg_chk (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic interrupt_out_n_o,
  input wire logic interrupt_out_n_oe_o,
  input wire logic [9:0] oversample_ratio_o,
  input wire logic [7:0] rate_interval_count_o,
  input wire logic [5:0] light2_gain_o,
  input wire logic [6:0] led_pulse_us_o,
  input wire logic [8:0] analog_samples_o,
  input wire logic [22:0] idle_ticks_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  // ====
  // Pins
  a_pin_oe_pair: assert property (interrupt_out_n_oe_o == !interrupt_out_n_o)
    else $error("interrupt pin and its enable disagree");
  a_sda_drive_low: assert property (sda_oe_o |-> !sda_o)
    else $error("data pin driven high");
  a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !$past(scl_i))
    else $error("data pin moved while bus clock high");
  // ====
  // Decoded fields
  a_gain_pow2: assert property ($onehot0(light2_gain_o))
    else $error("gain not a power of two");
  a_osr_range: assert property ($onehot0(oversample_ratio_o)
    && oversample_ratio_o[4:0] == 5'h0) else $error("oversample ratio illegal");
  a_rate_pow2: assert property ($onehot0(rate_interval_count_o))
    else $error("rate interval illegal");
  a_sample_pow2: assert property ($onehot0(analog_samples_o))
    else $error("sample count illegal");
  a_pulse_span: assert property (led_pulse_us_o == 7'h0 || led_pulse_us_o inside {[7'h2:7'h41]})
    else $error("pulse width out of span");
  a_idle_span: assert property (idle_ticks_o inside {23'h0, [23'h280:23'h61A800]})
    else $error("idle time out of span");
  // Skips reset loads; later changes follow a byte in a low clock phase
  a_decode_after_byte: assert property ($past(nrst_i, 2) &&
    $changed({oversample_ratio_o, idle_ticks_o}) |-> !$past(scl_i))
    else $error("decoded field changed outside a bus byte");
  c_ack: cover property ($rose(sda_oe_o));
  c_irq: cover property ($fell(interrupt_out_n_o));
  c_idle: cover property ($changed(idle_ticks_o));
endmodule : osc_cfg_chk

bind optical_sensor_config_regs osc_cfg_chk chk_u (.clk_i, .nrst_i, .scl_i, .sda_o, .sda_oe_o,
  .interrupt_out_n_o, .interrupt_out_n_oe_o, .oversample_ratio_o, .rate_interval_count_o,
  .light2_gain_o, .led_pulse_us_o, .analog_samples_o, .idle_ticks_o);

// [i2c_host_model.sv]
// Purpose: I2C controller model
// Assumes: Tasks start just after a clock edge
// Notes: SDA only released or pulled low
module i2c_host_model (
  input wire logic clk_i,
  input wire logic sda_w_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  // ====
  // Phases last one clock or more for the target
  task automatic pin(input logic c, input logic d, input int n);
    scl_o <= c;
    sda_o <= d;
    repeat (n) @(posedge clk_i);
  endtask : pin
  task automatic bit_io(input logic b, output logic r);
    pin(1'h0, b, 2);
    pin(1'h1, b, 3);
    r = sda_w_i;
    pin(1'h0, b, 1);
  endtask : bit_io
  task automatic start();
    pin(1'h1, 1'h0, 3);
    pin(1'h0, 1'h0, 1);
  endtask : start
  task automatic rstart();
    pin(1'h0, 1'h1, 2);
    pin(1'h1, 1'h1, 3);
    pin(1'h1, 1'h0, 3);
    pin(1'h0, 1'h0, 1);
  endtask : rstart
  task automatic stop();
    pin(1'h0, 1'h0, 2);
    pin(1'h1, 1'h0, 3);
    pin(1'h1, 1'h1, 4);
  endtask : stop
  task automatic send(input logic [7:0] d, output logic acked);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'h1, r);
    acked = !r;
  endtask : send
  task automatic get(input logic last, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'h1, q[i]);
    bit_io(last, r);
  endtask : get
endmodule : i2c_host_model

// [testbench.sv]
// Purpose: Self-checking bench for the sensor bank
// Assumes: SDA pulled up; host model owns SCL
// Notes: Interrupt pulse width shortened to keep runs brief
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] AW = {sensor_cfg_pkg::TARGET_ADDR, 1'h0};
  logic clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic en_i = 1'h1;
  logic prox_sample_i = 1'h0;
  logic [3:0] prox_cond_i = 4'h0;
  logic scl_i, sda_h, sda_o, sda_oe_o, interrupt_out_n_o, interrupt_out_n_oe_o;
  logic [9:0] oversample_ratio_o;
  logic [7:0] rate_interval_count_o;
  logic [5:0] light2_gain_o;
  logic [24:0] analog_front_end_offset_o;
  logic [6:0] led_pulse_us_o;
  logic [3:0] led_current_ma_o;
  logic [8:0] analog_samples_o;
  logic [22:0] idle_ticks_o;
  int mismatches = 0;
  int cmp_count = 0;
  wire sda_i = sda_h & ~sda_oe_o;
  always #10 clk_i = ~clk_i;
  optical_sensor_config_regs dut_u (.clk_i, .nrst_i, .en_i, .scl_i, .sda_i, .sda_o,
    .sda_oe_o, .prox_sample_i, .prox_cond_i, .interrupt_out_n_o, .interrupt_out_n_oe_o,
    .light2_continuous_o(), .light2_enable_o(), .averaging_count_o(), .oversample_ratio_o,
    .rate_interval_count_o, .light2_gain_o, .light3_gain_o(), .light4_gain_o(),
    .analog_front_end_offset_o, .led_pulse_us_o, .led_current_ma_o, .analog_samples_o,
    .digital_samples_o(), .idle_ticks_o, .prox_high1_o(), .prox_low1_o(),
    .baseline_rise_limit_o(), .proximity_baseline_low_o());
  i2c_host_model host_u (.clk_i, .sda_w_i(sda_i), .scl_o(scl_i), .sda_o(sda_h));
  // ====
  // Helpers
  task automatic wrap_up();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic tx(input logic [7:0] d);
    logic a;
    host_u.send(d, a);
    chk(a, 1'h1);
  endtask : tx
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host_u.start();
    tx(AW);
    tx(idx);
    tx(d);
    host_u.stop();
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] q;
    host_u.start();
    tx(AW);
    tx(idx);
    host_u.rstart();
    tx(AW | 8'h01);
    host_u.get(1'h1, q);
    host_u.stop();
    chk(q, e);
  endtask : rdc
  task automatic hit(input logic [3:0] c);
    prox_cond_i <= c;
    prox_sample_i <= 1'h1;
    @(posedge clk_i);
    prox_sample_i <= 1'h0;
    repeat (4) @(posedge clk_i);
  endtask : hit
  // ====
  // Scenarios
  task automatic t_reset();
    chk(oversample_ratio_o, 10'h200);
    chk(light2_gain_o, 6'h20);
    chk(idle_ticks_o, 23'h27100);
    chk(led_pulse_us_o, 7'h3F);
    chk(led_current_ma_o, 4'hF);
    chk(analog_samples_o, 9'h004);
    chk({interrupt_out_n_o, interrupt_out_n_oe_o, sda_oe_o}, 3'h4);
    rdc(8'h83, 8'h01);
  endtask : t_reset
  task automatic t_addr();
    logic a;
    host_u.start();
    host_u.send(8'h58, a);
    chk(a, 1'h0);
    host_u.stop();
  endtask : t_addr
  task automatic t_fields();
    for (int c = 0; c < 8; c++) begin
      wr(8'h33, 8'(c));
      chk(rate_interval_count_o, 8'h01 << c);
      wr(8'h39, 8'(c));
      chk(light2_gain_o, (c > 0 && c < 7) ? 6'h01 << (c - 1) : 6'h00);
      wr(8'h31, 8'(c << 4));
      chk(oversample_ratio_o, 10'h020 << (c > 4 ? 4 : c));
    end
    wr(8'h5A, 8'h08);
    chk(analog_samples_o, 9'h100);
    wr(8'h80, 8'h00);
    chk(idle_ticks_o, 23'h0);
    wr(8'h80, 8'h1F);
    chk(idle_ticks_o, 23'h61A800);
    wr(8'h53, 8'hFC);
    chk(led_pulse_us_o, 7'h41);
    wr(8'hE3, 8'h08);
    chk(led_current_ma_o, 4'h1);
    rdc(8'h35, 8'h00);
  endtask : t_fields
  task automatic t_burst();
    logic [31:0] q;
    logic [7:0] b;
    host_u.start();
    tx(AW);
    tx(8'h3A);
    for (int i = 0; i < 4; i++) tx(8'h11 * 8'(i + 1) | 8'(i == 3));
    host_u.stop();
    chk(analog_front_end_offset_o, 25'h1332211);
    host_u.start();
    tx(AW);
    tx(8'h3A);
    host_u.rstart();
    tx(AW | 8'h01);
    for (int i = 0; i < 4; i++) begin
      host_u.get(i == 3, b);
      q[8*i +: 8] = b;
    end
    host_u.stop();
    chk(q, 32'h01332211);
  endtask : t_burst
  task automatic t_irq();
    wr(8'h87, 8'h02);
    wr(8'h88, 8'h00);
    wr(8'h62, 8'h01);
    hit(4'h1);
    chk(interrupt_out_n_o, 1'h1);
    hit(4'h1);
    chk({interrupt_out_n_o, interrupt_out_n_oe_o}, 2'h1);
    repeat (150) @(posedge clk_i);
    chk(interrupt_out_n_o, 1'h1);
    rdc(8'h18, 8'h01);
    wr(8'h83, 8'h41);
    chk(interrupt_out_n_o, 1'h0);
    wr(8'h83, 8'h61);
    chk(interrupt_out_n_o, 1'h1);
    rdc(8'h18, 8'h00);
    rdc(8'h83, 8'h41);
    wr(8'h14, 8'h12);
    hit(4'h2);
    hit(4'h2);
    chk(interrupt_out_n_o, 1'h0);
    rdc(8'h18, 8'h02);
    rdc(8'h18, 8'h00);
    chk(interrupt_out_n_o, 1'h1);
  endtask : t_irq
  task automatic t_timeout();
    wr(8'h84, 8'h03);
    wr(8'h83, 8'h45);
    repeat (200) @(posedge clk_i);
    rdc(8'h86, 8'h02);
    chk(interrupt_out_n_o, 1'h0);
  endtask : t_timeout
  initial begin
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_addr();
    t_fields();
    t_burst();
    t_irq();
    t_timeout();
    wrap_up();
  end
  // Watchdog
  initial begin
    #1_000_000;
    mismatches++;
    wrap_up();
  end
endmodule : testbench
